// ===== logic/ssh_params.svh
// Register offsets, field positions, reset values and counts of the signal monitor
`ifndef SSH_PARAMS_SVH
`define SSH_PARAMS_SVH

`define SSH_UNIT_SEL_BIT       5
`define SSH_OFF_CONTROL        5'h00
`define SSH_OFF_ADDRESS        5'h04
`define SSH_OFF_DATA           5'h08
`define SSH_OFF_LOWER          5'h0c
`define SSH_OFF_UPPER          5'h10
`define SSH_OFF_SHIFT          5'h14
`define SSH_OFF_DURATION       5'h18
`define SSH_OFF_STATUS         5'h1c

`define SSH_CTL_MODE_LSB       0
`define SSH_CTL_MODE_MSB       1
`define SSH_CTL_TAP_LSB        2
`define SSH_CTL_TAP_MSB        4
`define SSH_CTL_FUNC_LSB       5
`define SSH_CTL_FUNC_MSB       6
`define SSH_CTL_CLEAR_BIT      7

`define SSH_STS_CLEAR_BIT      0
`define SSH_STS_CAP_DONE_BIT   1
`define SSH_STS_HIST_DONE_BIT  2

`define SSH_RST_CONTROL        8'h00
`define SSH_RST_ADDRESS        11'h000
`define SSH_RST_LOWER          16'h8000
`define SSH_RST_UPPER          16'h7fff
`define SSH_RST_SHIFT          5'h00
`define SSH_RST_DURATION       16'h0000

`define SSH_LAST_WORD_ADDR     11'h7ff
`define SSH_SAMPLES_PER_UNIT   11'h400
`define SSH_LAST_BIN           10'h3ff
`define SSH_DURATION_LOG2      16
`define SSH_MAG_CLAMP          16'h7fff

`endif

// ===== logic/ssh_pkg.sv
// Types shared by the signal monitor top and its memory unit
package ssh_pkg;

	typedef struct packed {
		logic [17:0] i;
		logic [17:0] q;
	} ssh_sample_t;

	typedef enum logic [1:0] {
		SSH_MODE_OFF     = 2'h0,
		SSH_MODE_CAPTURE = 2'h1,
		SSH_MODE_HIST    = 2'h2
	} ssh_mode_t;

	typedef enum logic [1:0] {
		SSH_FUNC_I   = 2'h0,
		SSH_FUNC_Q   = 2'h1,
		SSH_FUNC_MAG = 2'h2
	} ssh_func_t;

	typedef enum logic [1:0] {
		SSH_CLR_IDLE  = 2'b01,
		SSH_CLR_SWEEP = 2'b10
	} ssh_clr_state_t;

	typedef struct packed {
		logic        valid;
		logic [9:0]  index;
		logic [31:0] data;
	} ssh_cap_req_t;

	typedef struct packed {
		logic        valid;
		logic [9:0]  bin;
	} ssh_hist_req_t;

endpackage : ssh_pkg

// ===== logic/ssh_monitor_ram.sv
// One monitor memory: 1024 words of 32 bits seen by the host as 2048 half-words
`timescale 1ns/1ps
`include "ssh_params.svh"
module ssh_monitor_ram (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	input  wire logic [10:0]          host_addr,
	input  wire logic                 host_we,
	input  wire logic [15:0]          host_wdata,
	output logic      [15:0]          host_rdata,
	input  wire logic                 clear_req,
	output logic                      clear_busy,
	output logic                      clear_done,
	input  wire ssh_pkg::ssh_cap_req_t  cap_req,
	input  wire ssh_pkg::ssh_hist_req_t hist_req
);
	import ssh_pkg::*;

	logic [31:0]    mem [0:1023];
	ssh_clr_state_t clr_state_reg;
	logic [9:0]     clr_idx_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			clr_state_reg <= SSH_CLR_IDLE;
			clr_idx_reg   <= 10'h000;
		end else begin
			case (clr_state_reg)
				SSH_CLR_IDLE: begin
					clr_idx_reg <= 10'h000;
					if (clear_req) begin
						clr_state_reg <= SSH_CLR_SWEEP;
					end
				end
				SSH_CLR_SWEEP: begin
					clr_idx_reg <= clr_idx_reg + 10'h001;
					if (clr_idx_reg == `SSH_LAST_BIN) begin
						clr_state_reg <= SSH_CLR_IDLE;
					end
				end
				default: clr_state_reg <= SSH_CLR_IDLE;
			endcase
		end
	end

	assign clear_busy = (clr_state_reg == SSH_CLR_SWEEP);
	assign clear_done = clear_busy && (clr_idx_reg == `SSH_LAST_BIN);

	// Sweep wins over everything, host over the datapath
	always_ff @(posedge ref_clk) begin
		if (clear_busy) begin
			mem[clr_idx_reg] <= 32'h0000_0000;
		end else if (host_we) begin
			if (host_addr[0]) begin
				mem[host_addr[10:1]][15:0] <= host_wdata;
			end else begin
				mem[host_addr[10:1]][31:16] <= host_wdata;
			end
		end else if (cap_req.valid) begin
			mem[cap_req.index] <= cap_req.data;
		end else if (hist_req.valid) begin
			mem[hist_req.bin] <= mem[hist_req.bin] + 32'h0000_0001;
		end
	end

	assign host_rdata = host_addr[0] ? mem[host_addr[10:1]][15:0] : mem[host_addr[10:1]][31:16];

endmodule : ssh_monitor_ram

// ===== logic/ssh_snapshot_hist.sv
// Two-unit signal snapshot and histogram monitor with an APB register port
`timescale 1ns/1ps
`include "ssh_params.svh"
module ssh_snapshot_hist #(
	parameter int NUM_TAPS = 5,
	parameter int PADDR_W  = 12
) (
	input  wire logic                                ref_clk,
	input  wire logic                                rst_b,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [PADDR_W-1:0]                  paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire ssh_pkg::ssh_sample_t [NUM_TAPS-1:0] tap_data,
	input  wire logic                                tap_valid
);
	import ssh_pkg::*;

	if (NUM_TAPS < 1 || NUM_TAPS > 8) begin : g_bad_taps
		$error("NUM_TAPS must lie in 1..8");
	end
	if (PADDR_W < 7) begin : g_bad_addr
		$error("PADDR_W too small for the register map");
	end

	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        acc_first;
	logic        acc_done;
	logic        addr_ok;
	logic        unit_sel;
	logic [4:0]  reg_off;
	logic [31:0] unit_rd [2];

	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign reg_off  = paddr[4:0];
	assign unit_sel = paddr[`SSH_UNIT_SEL_BIT];
	assign addr_ok  = (paddr[PADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0);

	// One wait state: answer on the second access cycle
	assign acc_first = psel && penable && !pready_reg;
	assign acc_done  = psel && penable && pready_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= acc_first;
		end
	end

	// Unmapped or unaligned offsets answer with an error and change nothing
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= acc_first && !addr_ok;
		end
	end

	// Data sampled before the address steps
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			prdata_reg <= 32'h0000_0000;
		end else if (acc_first && !pwrite) begin
			prdata_reg <= addr_ok ? unit_rd[unit_sel] : 32'h0000_0000;
		end
	end

	for (genvar u = 0; u < 2; u++) begin : g_unit
		logic          sel_me;
		logic          wr_ctl;
		logic          wr_addr;
		logic          data_acc;
		logic          wr_lower;
		logic          wr_upper;
		logic          wr_shift;
		logic          wr_dur;
		logic [7:0]    control_reg;
		logic [10:0]   address_reg;
		logic [15:0]   lower_reg;
		logic [15:0]   upper_reg;
		logic [4:0]    shift_reg;
		logic [15:0]   duration_reg;
		logic [10:0]   cap_ptr_reg;
		logic [31:0]   hist_cnt_reg;
		logic [1:0]    mode_prev_reg;
		logic [15:0]   func_val_reg;
		logic          func_vld_reg;
		logic [2:0]    tap_sel;
		ssh_mode_t     mode;
		ssh_func_t     func;
		ssh_sample_t   sample;
		logic          clear_busy;
		logic          clear_done;
		logic          cap_done;
		logic          hist_done;
		logic          mode_entry;
		logic [15:0]   host_rdata;
		logic          host_we;
		logic [15:0]   func_now;
		logic          in_range;
		logic [16:0]   diff;
		logic [16:0]   shifted;
		logic [31:0]   rd_word;
		ssh_cap_req_t  cap_req;
		ssh_hist_req_t hist_req;

		assign sel_me   = addr_ok && (unit_sel == 1'(u));
		assign wr_ctl   = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_CONTROL);
		assign wr_addr  = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_ADDRESS);
		assign data_acc = acc_done && sel_me && (reg_off == `SSH_OFF_DATA);
		assign wr_lower = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_LOWER);
		assign wr_upper = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_UPPER);
		assign wr_shift = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_SHIFT);
		assign wr_dur   = acc_done && pwrite && sel_me && (reg_off == `SSH_OFF_DURATION);
		// Host writes land only while the unit is idle, so the datapath keeps the port
		assign host_we  = data_acc && pwrite && (mode == SSH_MODE_OFF);
		assign tap_sel  = control_reg[`SSH_CTL_TAP_MSB:`SSH_CTL_TAP_LSB];
		assign func     = ssh_func_t'(control_reg[`SSH_CTL_FUNC_MSB:`SSH_CTL_FUNC_LSB]);
		assign mode_entry = (control_reg[`SSH_CTL_MODE_MSB:`SSH_CTL_MODE_LSB] != mode_prev_reg);

		// Unused mode code acts as off
		always_comb begin
			case (control_reg[`SSH_CTL_MODE_MSB:`SSH_CTL_MODE_LSB])
				2'h1:    mode = SSH_MODE_CAPTURE;
				2'h2:    mode = SSH_MODE_HIST;
				default: mode = SSH_MODE_OFF;
			endcase
		end

		// Tap select, out-of-range picks the input
		assign sample = (int'(tap_sel) < NUM_TAPS) ? tap_data[tap_sel] : tap_data[0];

		// Clear bit, a new request wins over completion
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				control_reg <= `SSH_RST_CONTROL;
			end else if (wr_ctl) begin
				control_reg <= pwdata[7:0] | {clear_busy && !clear_done, 7'h00};
			end else if (clear_done) begin
				control_reg[`SSH_CTL_CLEAR_BIT] <= 1'b0;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				lower_reg <= `SSH_RST_LOWER;
			end else if (wr_lower) begin
				lower_reg <= pwdata[15:0];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				upper_reg <= `SSH_RST_UPPER;
			end else if (wr_upper) begin
				upper_reg <= pwdata[15:0];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				shift_reg <= `SSH_RST_SHIFT;
			end else if (wr_shift) begin
				shift_reg <= pwdata[4:0];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				duration_reg <= `SSH_RST_DURATION;
			end else if (wr_dur) begin
				duration_reg <= pwdata[15:0];
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				address_reg <= `SSH_RST_ADDRESS;
			end else if (wr_addr) begin
				address_reg <= pwdata[10:0];
			end else if (data_acc) begin
				if (address_reg == `SSH_LAST_WORD_ADDR) begin
					address_reg <= 11'h000;
				end else begin
					address_reg <= address_reg + 11'h001;
				end
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				mode_prev_reg <= 2'h0;
			end else begin
				mode_prev_reg <= control_reg[`SSH_CTL_MODE_MSB:`SSH_CTL_MODE_LSB];
			end
		end

		assign cap_done = (cap_ptr_reg == `SSH_SAMPLES_PER_UNIT);

		// Capture stops once full so the host reads a coherent record
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				cap_ptr_reg <= 11'h000;
			end else if (mode_entry || clear_busy) begin
				cap_ptr_reg <= 11'h000;
			end else if (cap_req.valid) begin
				cap_ptr_reg <= cap_ptr_reg + 11'h001;
			end
		end

		always_comb begin
			// Entry cycle skipped: the pointer is being restarted then
			cap_req.valid = (mode == SSH_MODE_CAPTURE) && tap_valid && !cap_done && !clear_busy && !host_we &&
				!mode_entry;
			cap_req.index = cap_ptr_reg[9:0];
			cap_req.data  = {sample.i[17:2], sample.q[17:2]};
		end

		// Zero duration means collect without end
		assign hist_done = (duration_reg != 16'h0000) &&
			(hist_cnt_reg >= {duration_reg, {`SSH_DURATION_LOG2{1'b0}}});

		always_comb begin
			logic signed [15:0] si;
			logic signed [15:0] sq;
			logic        [31:0] mag;
			si  = signed'(sample.i[17:2]);
			sq  = signed'(sample.q[17:2]);
			mag = 32'(si * si) + 32'(sq * sq);
			case (func)
				SSH_FUNC_I: func_now = sample.i[17:2];
				SSH_FUNC_Q: func_now = sample.q[17:2];
				// Drop low half, clamp full-scale corner
				default:    func_now = mag[31] ? `SSH_MAG_CLAMP : mag[31:16];
			endcase
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				func_val_reg <= 16'h0000;
				func_vld_reg <= 1'b0;
			end else begin
				func_val_reg <= func_now;
				func_vld_reg <= (mode == SSH_MODE_HIST) && tap_valid && !hist_done && !clear_busy &&
					!mode_entry;
			end
		end

		// Every sample counts toward the duration limit, in range or not
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				hist_cnt_reg <= 32'h0000_0000;
			end else if (mode_entry || clear_busy) begin
				hist_cnt_reg <= 32'h0000_0000;
			end else if ((mode == SSH_MODE_HIST) && tap_valid && !hist_done) begin
				hist_cnt_reg <= hist_cnt_reg + 32'h0000_0001;
			end
		end

		assign in_range = ($signed(func_val_reg) >= $signed(lower_reg)) &&
			($signed(func_val_reg) <= $signed(upper_reg));
		assign diff    = 17'({func_val_reg[15], func_val_reg} - {lower_reg[15], lower_reg});
		assign shifted = diff >> shift_reg;

		always_comb begin
			hist_req.valid = func_vld_reg && in_range && !clear_busy && !host_we &&
				(mode == SSH_MODE_HIST);
			hist_req.bin   = shifted[9:0] & `SSH_LAST_BIN;
		end

		always_comb begin
			if (reg_off == `SSH_OFF_CONTROL) begin
				rd_word = {24'h000000, control_reg};
			end else if (reg_off == `SSH_OFF_ADDRESS) begin
				rd_word = {21'h000000, address_reg};
			end else if (reg_off == `SSH_OFF_DATA) begin
				rd_word = {16'h0000, host_rdata};
			end else if (reg_off == `SSH_OFF_LOWER) begin
				rd_word = {16'h0000, lower_reg};
			end else if (reg_off == `SSH_OFF_UPPER) begin
				rd_word = {16'h0000, upper_reg};
			end else if (reg_off == `SSH_OFF_SHIFT) begin
				rd_word = {27'h0000000, shift_reg};
			end else if (reg_off == `SSH_OFF_DURATION) begin
				rd_word = {16'h0000, duration_reg};
			end else begin
				rd_word = {29'h00000000, hist_done, cap_done, clear_busy};
			end
		end

		// One continuous driver per unit keeps the shared read array single-driven
		assign unit_rd[u] = rd_word;

		ssh_monitor_ram u_ram (
			.ref_clk    (ref_clk),
			.rst_b      (rst_b),
			.host_addr  (address_reg),
			.host_we    (host_we),
			.host_wdata (pwdata[15:0]),
			.host_rdata (host_rdata),
			.clear_req  (control_reg[`SSH_CTL_CLEAR_BIT]),
			.clear_busy (clear_busy),
			.clear_done (clear_done),
			.cap_req    (cap_req),
			.hist_req   (hist_req)
		);
	end

endmodule : ssh_snapshot_hist

// ===== verification/ssh_snapshot_hist_props.sv
// Concurrent checks on the register port of the signal monitor
`timescale 1ns/1ps
`include "ssh_params.svh"
module ssh_snapshot_hist_props #(
	parameter int NUM_TAPS = 5,
	parameter int PADDR_W  = 12
) (
	input wire logic                                ref_clk,
	input wire logic                                rst_b,
	input wire logic                                psel,
	input wire logic                                penable,
	input wire logic                                pwrite,
	input wire logic [PADDR_W-1:0]                  paddr,
	input wire logic [31:0]                         pwdata,
	input wire logic [31:0]                         prdata,
	input wire logic                                pready,
	input wire logic                                pslverr,
	input wire ssh_pkg::ssh_sample_t [NUM_TAPS-1:0] tap_data,
	input wire logic                                tap_valid
);
	import ssh_pkg::*;
	logic        ok_rd;
	logic        ok_wr;
	logic [10:0] addr_reg [2];
	logic [10:0] clr_reg;
	assign ok_rd = psel && penable && pready && !pslverr && !pwrite;
	assign ok_wr = psel && penable && pready && !pslverr && pwrite;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// Mirror of both address registers; 11 bits wrap by themselves
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_reg[0] <= 11'h000;
			addr_reg[1] <= 11'h000;
		end else if (ok_wr && paddr[4:0] == `SSH_OFF_ADDRESS) begin
			addr_reg[paddr[5]] <= pwdata[10:0];
		end else if ((ok_rd || ok_wr) && paddr[4:0] == `SSH_OFF_DATA) begin
			addr_reg[paddr[5]] <= addr_reg[paddr[5]] + 11'h001;
		end
	end
	// Cycles since a clear of unit A was taken, stops well short of the sweep
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			clr_reg <= 11'h000;
		end else if (ok_wr && paddr[5:0] == 6'h00 && pwdata[`SSH_CTL_CLEAR_BIT]) begin
			clr_reg <= 11'h001;
		end else if (clr_reg != 11'h000) begin
			clr_reg <= (clr_reg == 11'h3e8) ? 11'h000 : clr_reg + 11'h001;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	a_ready_gated: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
	a_err_unmapped: assert property (pready && (paddr[1:0] != 2'b00 || paddr[PADDR_W-1:6] != '0) |-> pslverr)
		else $error("unmapped access without error");
	a_err_quiet: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read returned data");
	a_addr_unit_a: assert property (ok_rd && paddr[5:0] == 6'h04 |-> prdata[10:0] == addr_reg[0])
		else $error("unit A address step wrong");
	a_addr_unit_b: assert property (ok_rd && paddr[5:0] == 6'h24 |-> prdata[10:0] == addr_reg[1])
		else $error("unit B address step wrong");
	a_clear_busy: assert property (ok_rd && paddr[5:0] == 6'h1c && clr_reg > 11'h002 |-> prdata[0])
		else $error("clear not busy during sweep");
endmodule : ssh_snapshot_hist_props

// ===== verification/ssh_apb_host.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`include "ssh_params.svh"
module ssh_apb_host (
	input  wire logic        ref_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// Request held until pready is sampled high; released lines show the inverse
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask : xfer
	task automatic clear_unit(input int u, output logic [31:0] rd);
		logic e;
		int n;
		xfer(1'b1, 12'(u * 32), 32'h80, rd, e);
		n = 0;
		do begin
			xfer(1'b0, 12'(u * 32) + 12'(`SSH_OFF_STATUS), 32'h0, rd, e);
			n++;
		end while (rd[`SSH_STS_CLEAR_BIT] !== 1'b0 && n < 600);
	endtask : clear_unit
endmodule : ssh_apb_host

// ===== verification/ssh_snapshot_hist_tb_top.sv
// Self-checking testbench for the two-unit signal monitor
`timescale 1ns/1ps
`include "ssh_params.svh"
module ssh_snapshot_hist_tb_top;
	import ssh_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	ssh_sample_t [4:0] tap_data = '0;
	logic              tap_valid = 1'b0;
	logic [31:0]       rd;
	logic              er;
	int                n_errors = 0;
	int                samples_checked = 0;
	logic [15:0]       cap_exp [2][2048];
	logic [31:0]       hist_exp [2][1024];
	int                tap_sel [2];
	int                fn_sel [2];
	logic [15:0]       lo_s [2];
	logic [15:0]       hi_s [2];
	int                sh_s [2];

	always #5 ref_clk = ~ref_clk;

	ssh_snapshot_hist #(.NUM_TAPS(5), .PADDR_W(12)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tap_data(tap_data), .tap_valid(tap_valid));
	ssh_apb_host u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	function automatic logic [15:0] fval(ssh_sample_t s, int f);
		int     a;
		int     b;
		longint m;
		a = $signed(s.i[17:2]);
		b = $signed(s.q[17:2]);
		m = longint'(a * a) + longint'(b * b);
		if (f == 0) return s.i[17:2];
		if (f == 1) return s.q[17:2];
		return (m >= 64'h8000_0000) ? 16'h7fff : 16'(m >> 16);
	endfunction : fval

	function automatic int bin_of(logic [15:0] v, logic [15:0] lo, logic [15:0] hi, int sh);
		if ($signed(v) < $signed(lo) || $signed(v) > $signed(hi)) return -1;
		return ((int'($signed(v)) - int'($signed(lo))) >> sh) & 1023;
	endfunction : bin_of

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input int u, input logic [4:0] off, input logic [31:0] d);
		u_host.xfer(1'b1, 12'(u * 32) + 12'(off), d, rd, er);
	endtask : wr
	task automatic rdw(input int u, input logic [4:0] off);
		u_host.xfer(1'b0, 12'(u * 32) + 12'(off), 32'h0, rd, er);
	endtask : rdw

	// Random samples on all taps with idle gaps; the model follows each unit's tap
	task automatic feed(input int n, input int md);
		ssh_sample_t [4:0] s;
		int                k;
		int                b;
		logic              v;
		k = 0;
		while (k < n) begin
			@(posedge ref_clk);
			for (int t = 0; t < 5; t++) begin
				s[t].i = 18'(int'($urandom % 65536) - 32768);
				s[t].q = 18'(int'($urandom % 65536) - 32768);
			end
			v = ($urandom % 4) != 0;
			tap_data <= s;
			tap_valid <= v;
			for (int u = 0; u < 2 && v; u++) begin
				if (md == 1 && k < 1024) begin
					cap_exp[u][2 * k] = s[tap_sel[u]].i[17:2];
					cap_exp[u][2 * k + 1] = s[tap_sel[u]].q[17:2];
				end
				b = bin_of(fval(s[tap_sel[u]], fn_sel[u]), lo_s[u], hi_s[u], sh_s[u]);
				if (md == 2 && b >= 0) hist_exp[u][b]++;
			end
			k += int'(v);
		end
		@(posedge ref_clk);
		tap_valid <= 1'b0;
	endtask : feed

	// One read past the end checks the wrap back to word zero
	task automatic readall(input int u, input int md);
		logic [15:0] e;
		int          k;
		wr(u, `SSH_OFF_ADDRESS, 32'h0);
		for (int a = 0; a <= 2048; a++) begin
			rdw(u, `SSH_OFF_DATA);
			k = a % 2048;
			e = (md == 1) ? cap_exp[u][k] : (k % 2 == 0 ? hist_exp[u][k / 2][31:16] : hist_exp[u][k / 2][15:0]);
			chk("memory word", rd[15:0], e);
		end
		rdw(u, `SSH_OFF_ADDRESS);
		chk("address step", rd[15:0], 16'h0001);
	endtask : readall

	task automatic close_out();
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	initial begin
		void'($urandom(14581));
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int u = 0; u < 2; u++) begin
			rdw(u, `SSH_OFF_LOWER);
			chk("lower reset", rd[15:0], `SSH_RST_LOWER);
			rdw(u, `SSH_OFF_UPPER);
			chk("upper reset", rd[15:0], `SSH_RST_UPPER);
			rdw(u, `SSH_OFF_CONTROL);
			chk("mode reset", 16'(rd[1:0]), 16'(SSH_MODE_OFF));
		end
		u_host.xfer(1'b0, 12'h046, 32'h0, rd, er);
		chk("unmapped", {15'h0, er}, 16'h0001);
		// Two capture rounds then two histogram rounds; taps and functions rotate
		for (int r = 0; r < 4; r++) begin
			for (int u = 0; u < 2; u++) begin
				tap_sel[u] = (r + 3 * u) % 5;
				fn_sel[u] = (r + u) % 3;
				lo_s[u] = 16'(-int'($urandom % 2048));
				hi_s[u] = lo_s[u] + 16'($urandom % 8192);
				sh_s[u] = $urandom % 4;
				if (r == 3 && u == 1) begin
					lo_s[u] = 16'h8000;
					hi_s[u] = 16'h7fff;
					sh_s[u] = 6;
				end
				hist_exp[u] = '{default: 32'h0};
				wr(u, `SSH_OFF_LOWER, {16'h0, lo_s[u]});
				wr(u, `SSH_OFF_UPPER, {16'h0, hi_s[u]});
				wr(u, `SSH_OFF_SHIFT, 32'(sh_s[u]));
				rdw(u, `SSH_OFF_LOWER);
				chk("lower bound", rd[15:0], lo_s[u]);
				u_host.clear_unit(u, rd);
				chk("clear done", 16'(rd[0]), 16'h0000);
				wr(u, `SSH_OFF_CONTROL, 32'(fn_sel[u] * 32 + tap_sel[u] * 4 + (r < 2 ? 1 : 2)));
			end
			feed(1100, r < 2 ? 1 : 2);
			// Capture full after 1024 samples; zero duration never ends a histogram
			for (int u = 0; u < 2; u++) begin
				rdw(u, `SSH_OFF_STATUS);
				chk("done flags", 16'(rd[2:1]), (r < 2) ? 16'h0001 : 16'h0000);
			end
			// Units off: further samples must leave memory alone
			for (int u = 0; u < 2; u++)
				wr(u, `SSH_OFF_CONTROL, 32'h0);
			feed(64, 0);
			for (int u = 0; u < 2; u++)
				readall(u, r < 2 ? 1 : 2);
		end
		// Host word written while off, then the address wraps from the last word
		wr(0, `SSH_OFF_ADDRESS, 32'h7ff);
		wr(0, `SSH_OFF_DATA, 32'h1234);
		rdw(0, `SSH_OFF_ADDRESS);
		chk("address wrap", rd[15:0], 16'h0000);
		wr(0, `SSH_OFF_ADDRESS, 32'h7ff);
		rdw(0, `SSH_OFF_DATA);
		chk("host word", rd[15:0], 16'h1234);
		close_out();
	end

	initial begin
		#990000;
		n_errors++;
		close_out();
	end
endmodule : ssh_snapshot_hist_tb_top

bind ssh_snapshot_hist ssh_snapshot_hist_props #(.NUM_TAPS(NUM_TAPS), .PADDR_W(PADDR_W)) u_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tap_data(tap_data),
	.tap_valid(tap_valid));
